// ===== logic/pwm_sec_timebase.sv
// secondary time base, chop generator, shared duty and protection key logic
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sec_consts.svh"
module pwm_sec_timebase
    import pwm_sec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic write_protect_config,
    input wire logic sync_in,
    input wire logic fault_event,
    input wire logic current_limit_event,
    input wire logic trigger_event,
    output logic sync_out,
    output logic special_event_trigger,
    output logic chop_clk,
    output logic [15:0] shared_duty,
    output logic [15:0] protected_value,
    output logic center_aligned_active,
    output logic fault_irq_pending,
    output logic current_limit_irq_pending,
    output logic trigger_irq_pending
);
    word_t ctrl_ff, period_ff, active_per_ff, cmp_ff, chop_ff, mduty_ff, key_ff, gen_ff, prot_ff;
    logic [2:0] sec_div_ff, pri_div_ff;
    logic pwm_module_enable_ff;
    logic pend_ff, per_pending_ff;
    logic [15:0] timer_ff;
    logic [6:0] sec_pre_ff, pri_pre_ff;
    logic [3:0] post_ff;
    logic [11:0] chop_cnt_ff;
    key_e key_st_ff;
    logic fault_pend_ff, cl_pend_ff, trg_pend_ff;
    logic sync_in_d_ff;
    logic wr_hit, sec_tick, pri_tick, boundary, match, sync_act, sync_rise;
    logic [6:0] sec_lim, pri_lim;
    logic [11:0] chop_lim;

    assign wr_hit = wr_stb;
    // prescaler: a one-cycle enable every 2^code input clocks [R04] [R13]
    assign sec_lim = 7'(7'h01 << sec_div_ff) - 7'h01;
    assign pri_lim = 7'(7'h01 << pri_div_ff) - 7'h01;
    assign sec_tick = (sec_pre_ff == sec_lim);
    assign pri_tick = (pri_pre_ff == pri_lim);
    assign sync_act = sync_in ^ ctrl_ff[`BIT_POL]; // [R01]
    assign sync_rise = sync_act & ~sync_in_d_ff;
    assign boundary = sec_tick && (timer_ff >= active_per_ff || (ctrl_ff[`BIT_EXTERNAL_SYNC_ENABLE] && sync_rise));
    // low three compare bits always read zero, so one match per period on eight-count steps [R08] [R09]
    assign match = sec_tick && (timer_ff == cmp_ff);
    assign chop_lim = {1'b0, chop_ff[9:3], 4'h0} + 12'h00F; // [R11] [R12]

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_in_d_ff <= 1'b0;
        end else begin
            sync_in_d_ff <= sync_act;
        end
    end

    // prescalers; reserved code 111 wraps the 7-bit limit and divides by 128
    always_ff @(posedge ref_clk) begin
        if (rst || !pwm_module_enable_ff) begin
            sec_pre_ff <= 7'h00;
            pri_pre_ff <= 7'h00;
        end else begin
            sec_pre_ff <= sec_tick ? 7'h00 : sec_pre_ff + 7'h01; // [R04]
            pri_pre_ff <= pri_tick ? 7'h00 : pri_pre_ff + 7'h01; // [R13]
        end
    end

    // secondary master timer and period load
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_ff <= `RST_ZERO;
            active_per_ff <= `RST_SEC_PER;
            per_pending_ff <= 1'b0;
        end else begin
            if (!pwm_module_enable_ff) begin
                timer_ff <= `RST_ZERO;
            end else if (boundary) begin
                timer_ff <= `RST_ZERO;
            end else if (sec_tick) begin
                timer_ff <= timer_ff + 16'h0001;
            end
            if (wr_hit && addr == `OFS_SEC_PER && ctrl_ff[`BIT_IMM]) begin
                active_per_ff <= wdata; // [R03]
                per_pending_ff <= 1'b0;
            end else if (wr_hit && addr == `OFS_SEC_PER) begin
                per_pending_ff <= 1'b1;
            end else if (per_pending_ff && (boundary || !pwm_module_enable_ff)) begin
                active_per_ff <= period_ff; // [R03]
                per_pending_ff <= 1'b0;
            end
        end
    end

    // sync output pulse, postscaled special event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_out <= 1'b0;
            post_ff <= 4'h0;
            special_event_trigger <= 1'b0;
        end else begin
            sync_out <= (ctrl_ff[`BIT_SOEN] & boundary) ^ ctrl_ff[`BIT_POL]; // [R01] [R02]
            special_event_trigger <= 1'b0;
            if (match) begin
                if (post_ff == ctrl_ff[3:0]) begin
                    post_ff <= 4'h0;
                    special_event_trigger <= 1'b1; // [R22]
                end else begin
                    post_ff <= post_ff + 4'h1;
                end
            end
        end
    end

    // special event pending: set wins over clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
        end else if (match && post_ff == ctrl_ff[3:0] && ctrl_ff[`BIT_IEN]) begin
            pend_ff <= 1'b1;
        end else if (wr_hit && addr == `OFS_STB_CTRL && !wdata[`BIT_PEND]) begin
            pend_ff <= 1'b0;
        end
    end

    // chop clock: toggles every 8*(div+1) primary ticks
    always_ff @(posedge ref_clk) begin
        if (rst || !chop_ff[`BIT_CHOP_EN]) begin
            chop_cnt_ff <= 12'h000; // [R10]
            chop_clk <= 1'b0;
        end else if (pri_tick) begin
            if (chop_cnt_ff[11:1] >= chop_lim[11:1]) begin
                chop_cnt_ff <= 12'h000;
                chop_clk <= ~chop_clk; // [R12]
            end else begin
                chop_cnt_ff <= chop_cnt_ff + 12'h002;
            end
        end
    end

    // unlock sequence; any other access in between relocks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_st_ff <= KEY_IDLE;
        end else if (wr_hit && addr == `OFS_KEY) begin
            unique case (key_st_ff)
                KEY_IDLE: key_st_ff <= (wdata == `KEY_FIRST) ? KEY_ONE : KEY_IDLE; // [R18]
                KEY_ONE: key_st_ff <= (wdata == `KEY_SECOND) ? KEY_OPEN : ((wdata == `KEY_FIRST) ? KEY_ONE : KEY_IDLE);
                KEY_OPEN: key_st_ff <= (wdata == `KEY_FIRST) ? KEY_ONE : KEY_IDLE;
            endcase
        end else if (wr_stb || rd_stb) begin
            key_st_ff <= KEY_IDLE; // [R18]
        end
    end

    // generator status flags; enable clear clears the flag, even against an event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_pend_ff <= 1'b0;
            cl_pend_ff <= 1'b0;
            trg_pend_ff <= 1'b0;
        end else begin
            fault_pend_ff <= (fault_event && gen_ff[12]) || (fault_pend_ff && gen_ff[12]); // [R21]
            cl_pend_ff <= (current_limit_event && gen_ff[11]) || (cl_pend_ff && gen_ff[11]); // [R21]
            trg_pend_ff <= (trigger_event && gen_ff[10]) || (trg_pend_ff && gen_ff[10]); // [R21]
        end
    end

    // register writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_ff <= `RST_ZERO;
            sec_div_ff <= 3'h0; // [R04]
            pri_div_ff <= 3'h0;
            period_ff <= `RST_SEC_PER;
            cmp_ff <= `RST_ZERO;
            chop_ff <= `RST_ZERO;
            mduty_ff <= `RST_ZERO;
            key_ff <= `RST_ZERO; // [R17]
            gen_ff <= `RST_ZERO;
            prot_ff <= `RST_ZERO;
            pwm_module_enable_ff <= 1'b0;
        end else if (wr_hit) begin
            unique case (addr)
                `OFS_STB_CTRL: ctrl_ff <= {4'h0, wdata[11:0]};
                `OFS_SEC_DIV: sec_div_ff <= wdata[2:0]; // [R05]
                `OFS_PRI_DIV: pri_div_ff <= wdata[2:0];
                `OFS_SEC_PER: period_ff <= wdata; // [R06] [R07]
                `OFS_SEC_CMP: cmp_ff <= {wdata[15:3], 3'h0}; // [R09]
                `OFS_CHOP: chop_ff <= {wdata[15], 5'h00, wdata[9:3], 3'h0}; // [R10] [R11]
                `OFS_MDUTY: mduty_ff <= wdata; // [R14] [R15]
                `OFS_KEY: key_ff <= wdata; // [R17]
                `OFS_GEN_CTRL: gen_ff <= {3'h0, wdata[12:0]};
                `OFS_PROT_REG: begin
                    if (!write_protect_config || key_st_ff == KEY_OPEN) begin
                        prot_ff <= wdata; // [R18] [R19]
                    end
                end
                `OFS_MOD_CTRL: pwm_module_enable_ff <= wdata[15];
                default: ;
            endcase
        end
    end

    // outputs and read port
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= `RST_ZERO;
            shared_duty <= `RST_ZERO;
            protected_value <= `RST_ZERO;
            center_aligned_active <= 1'b0;
            fault_irq_pending <= 1'b0;
            current_limit_irq_pending <= 1'b0;
            trigger_irq_pending <= 1'b0;
        end else begin
            shared_duty <= mduty_ff; // [R14] [R16]
            protected_value <= prot_ff;
            center_aligned_active <= gen_ff[`BIT_CAM] & gen_ff[`BIT_ITB]; // [R20]
            fault_irq_pending <= fault_pend_ff;
            current_limit_irq_pending <= cl_pend_ff;
            trigger_irq_pending <= trg_pend_ff;
            rdata <= `RST_ZERO;
            if (rd_stb) begin
                unique case (addr)
                    `OFS_STB_CTRL: rdata <= {3'h0, pend_ff, ctrl_ff[11:0]};
                    `OFS_SEC_DIV: rdata <= {13'h0000, sec_div_ff};
                    `OFS_PRI_DIV: rdata <= {13'h0000, pri_div_ff};
                    `OFS_SEC_PER: rdata <= period_ff;
                    `OFS_SEC_CMP: rdata <= cmp_ff;
                    `OFS_CHOP: rdata <= chop_ff;
                    `OFS_MDUTY: rdata <= mduty_ff;
                    `OFS_KEY: rdata <= key_ff;
                    `OFS_GEN_CTRL: rdata <= {fault_pend_ff, cl_pend_ff, trg_pend_ff, gen_ff[12:0]};
                    `OFS_PROT_REG: rdata <= prot_ff;
                    `OFS_MOD_CTRL: rdata <= {pwm_module_enable_ff, 15'h0000};
                    default: rdata <= `RST_ZERO;
                endcase
            end
        end
    end

    // a period write with immediate load must appear as the active period next cycle
    period_load_a: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
        (wr_stb && addr == `OFS_SEC_PER && ctrl_ff[`BIT_IMM]) |=> (active_per_ff == $past(wdata)))
        else $error("immediate period load missed");
    sync_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
        (!ctrl_ff[`BIT_SOEN] && !ctrl_ff[`BIT_POL]) |=> !sync_out)
        else $error("sync output active while disabled");
    chop_stop_a: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
        !chop_ff[`BIT_CHOP_EN] |=> !chop_clk)
        else $error("chop clock runs while disabled");
    cam_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [R20]
        !gen_ff[`BIT_ITB] |=> !center_aligned_active)
        else $error("center aligned without independent time base");
    lock_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [R19]
        (wr_stb && addr == `OFS_PROT_REG && write_protect_config && key_st_ff != KEY_OPEN)
        |=> $stable(prot_ff))
        else $error("locked register written");
    unlock_seq_a: assert property (@(posedge ref_clk) disable iff (rst) // [R18]
        (wr_stb && addr == `OFS_KEY && wdata == `KEY_FIRST) ##1
        (wr_stb && addr == `OFS_KEY && wdata == `KEY_SECOND) |=> key_st_ff == KEY_OPEN)
        else $error("unlock sequence not accepted");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // [R21]
        !gen_ff[12] |=> !fault_pend_ff)
        else $error("fault flag survives enable clear");
    post_trig_a: assert property (@(posedge ref_clk) disable iff (rst) // [R22]
        special_event_trigger |-> $past(match) && $past(post_ff) == $past(ctrl_ff[3:0]))
        else $error("special event without postscale count");
endmodule : pwm_sec_timebase
`default_nettype wire

// ===== inc/pwm_sec_consts.svh
// offsets, field positions, reset values and timing counts of the secondary time base block
// Operation
// R01 - polarity bit inverts sync input and sync output to active low
// R02 - sync output enable gates the sync pulse; clear keeps output idle
// R03 - immediate load bit: period loads on write, else at cycle boundary
// R04 - 3-bit prescaler divides by 1..64; code 111 reserved; reset divide-by-1
// R05 - software changes prescaler only while module enable is clear
// R06 - software keeps secondary period within 0x0010 to 0xFFF8
// R07 - periods below 0x0028 have low three bits zero
// R08 - 13-bit compare in bits 15..3 matched against secondary timer
// R09 - compare low three bits unimplemented, giving eight-count granularity
// R10 - chop enable bit 15 starts and stops the chop generator
// R11 - chop divider is a 7-bit field in bits 9..3
// R12 - chop period is 16 times (divider plus one) prescaled clocks
// R13 - chop generator is clocked after the primary prescaler
// R14 - a 16-bit shared duty value is held for the generators
// R15 - software keeps shared duty between 0x0008 and period minus 0x0008
// R16 - duty resolution may coarsen near 0% or 100%
// R17 - 16-bit read/write key register, reset value zero
// R18 - keys 0xABCD then 0x4321, next access must be the protected write
// R19 - protection on by default; configuration bit clear disables it
// R20 - center-aligned mode only acts when independent time base is set
// R21 - status flags set by events, cleared by clearing their enable
// R22 - postscaler issues a trigger on every Nth compare match
`ifndef PWM_SEC_CONSTS_SVH
`define PWM_SEC_CONSTS_SVH
`define ADR_W 4
`define OFS_STB_CTRL 4'h0
`define OFS_SEC_DIV 4'h1
`define OFS_SEC_PER 4'h2
`define OFS_SEC_CMP 4'h3
`define OFS_CHOP 4'h4
`define OFS_MDUTY 4'h5
`define OFS_KEY 4'h6
`define OFS_GEN_CTRL 4'h7
`define OFS_PROT_REG 4'h8
`define OFS_PRI_DIV 4'h9
`define OFS_MOD_CTRL 4'hA
`define RST_SEC_PER 16'hFFFF
`define RST_ZERO 16'h0000
`define KEY_FIRST 16'hABCD
`define KEY_SECOND 16'h4321
`define BIT_PEND 12
`define BIT_IEN 11
`define BIT_IMM 10
`define BIT_POL 9
`define BIT_SOEN 8
`define BIT_EXTERNAL_SYNC_ENABLE 7
`define BIT_SRC_LO 4
`define BIT_PS_LO 0
`define BIT_CHOP_EN 15
`define BIT_CHOP_LO 3
`define BIT_ITB 9
`define BIT_CAM 2
`define PS_RESERVED 3'h7
`define CHOP_HALF 8'h08
`endif

// ===== inc/pwm_sec_pkg.sv
// types of the secondary time base block
package pwm_sec_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} key_e;
endpackage : pwm_sec_pkg

// ===== verification/pwm_stage_model.sv
// far-side stand-in: drives fault, current-limit and trigger events and the sync input
`timescale 1ns/1ps
`default_nettype none
module pwm_stage_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] fire,
    input wire logic sync_lvl,
    output logic fault_event,
    output logic current_limit_event,
    output logic trigger_event,
    output logic sync_in
);
    // each request is registered onto its event line one cycle later, held as long as the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {fault_event, current_limit_event, trigger_event} <= 3'h0;
            sync_in <= 1'b0;
        end else begin
            {fault_event, current_limit_event, trigger_event} <= fire;
            sync_in <= sync_lvl;
        end
    end
endmodule : pwm_stage_model
`default_nettype wire

// ===== verification/pwm_secondary_timebase_chop_ctrl_test.sv
// register-level bench for the secondary time base block
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sec_consts.svh"
module pwm_secondary_timebase_chop_ctrl_test
    import pwm_sec_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    word_t wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic write_protect_config = 1'b1;
    logic [2:0] fire = 3'h0;
    logic sync_lvl = 1'b0;
    word_t rdata, shared_duty, protected_value, v;
    logic sync_in, fe, ce, te, sync_out, sev_trig, chop_clk, ca_act, fp, cp, tp;
    int fails = 0;
    int cmp_count = 0;
    int n, n1, cnt;

    pwm_sec_timebase i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .write_protect_config(write_protect_config),
        .sync_in(sync_in), .fault_event(fe), .current_limit_event(ce), .trigger_event(te),
        .sync_out(sync_out), .special_event_trigger(sev_trig), .chop_clk(chop_clk),
        .shared_duty(shared_duty), .protected_value(protected_value), .center_aligned_active(ca_act),
        .fault_irq_pending(fp), .current_limit_irq_pending(cp), .trigger_irq_pending(tp));
    pwm_stage_model i_stage (.ref_clk(ref_clk), .rst(rst), .fire(fire), .sync_lvl(sync_lvl), .fault_event(fe),
        .current_limit_event(ce), .trigger_event(te), .sync_in(sync_in));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task wr(input logic [3:0] a, input word_t d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task rd(input logic [3:0] a, output word_t d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task chk(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    function logic pick(input int s);
        case (s)
            0: return chop_clk;
            1: return sync_out;
            default: return sev_trig;
        endcase
    endfunction : pick

    // long waits are hang guards; short ones may legitimately see nothing
    task wait_sig(input int s, input logic lvl, input int lim, output int k);
        k = 0;
        for (int i = 1; i <= lim; i++) begin
            @(posedge ref_clk);
            #1;
            if (pick(s) === lvl) begin
                k = i;
                break;
            end
        end
        if (k == 0 && lim > 100) begin
            fails++;
            wrap_up();
        end
    endtask : wait_sig

    initial begin
        #1000000;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(i[3:0], v);
            chk(v, (i == 2) ? `RST_SEC_PER : `RST_ZERO);
        end
        $display("test 1 finished");
        wr(`OFS_SEC_CMP, 16'hFFFF);
        rd(`OFS_SEC_CMP, v);
        chk(v, 16'hFFF8);
        wr(`OFS_SEC_DIV, 16'hFFFF);
        rd(`OFS_SEC_DIV, v);
        chk(v, 16'h0007);
        wr(`OFS_CHOP, 16'hFFFF);
        rd(`OFS_CHOP, v);
        chk(v, 16'h83F8);
        wr(4'hB, 16'hFFFF);
        rd(4'hB, v);
        chk(v, 16'h0000);
        wr(`OFS_CHOP, 16'h0000);
        wr(`OFS_MDUTY, 16'h1234); // duty kept inside 0x0008..period-0x0008
        rd(`OFS_MDUTY, v);
        chk(v, 16'h1234);
        chk(shared_duty, 16'h1234);
        $display("test 2 finished");
        wr(`OFS_KEY, `KEY_FIRST);
        wr(`OFS_KEY, `KEY_SECOND);
        wr(`OFS_PROT_REG, 16'h5A5A);
        tick(2);
        chk(protected_value, 16'h5A5A);
        rd(`OFS_KEY, v);
        chk(v, `KEY_SECOND);
        wr(`OFS_PROT_REG, 16'h1111);
        wr(`OFS_KEY, `KEY_FIRST);
        rd(`OFS_KEY, v);
        wr(`OFS_KEY, `KEY_SECOND);
        wr(`OFS_PROT_REG, 16'h2222);
        tick(2);
        chk(protected_value, 16'h5A5A);
        // keys and the protected write back to back, no idle cycle between them
        @(posedge ref_clk);
        addr <= `OFS_KEY;
        wdata <= `KEY_FIRST;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wdata <= `KEY_SECOND;
        @(posedge ref_clk);
        addr <= `OFS_PROT_REG;
        wdata <= 16'h4444;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        tick(2);
        chk(protected_value, 16'h4444);
        @(posedge ref_clk);
        write_protect_config <= 1'b0;
        wr(`OFS_PROT_REG, 16'h3333);
        tick(2);
        chk(protected_value, 16'h3333);
        $display("test 3 finished");
        wr(`OFS_GEN_CTRL, 16'hE004);
        tick(2);
        chk({15'h0000, ca_act}, 16'h0000);
        rd(`OFS_GEN_CTRL, v);
        chk(v, 16'h0004);
        wr(`OFS_GEN_CTRL, 16'h0204);
        tick(2);
        chk({15'h0000, ca_act}, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_GEN_CTRL, 16'h1000 >> k);
            fire <= 3'h4 >> k;
            @(posedge ref_clk);
            fire <= 3'h0;
            tick(3);
            chk({13'h0000, fp, cp, tp}, 16'h0004 >> k);
            rd(`OFS_GEN_CTRL, v);
            chk(v, (16'h8000 >> k) | (16'h1000 >> k));
            wr(`OFS_GEN_CTRL, 16'h0000);
            fire <= 3'h4 >> k;
            @(posedge ref_clk);
            fire <= 3'h0;
            tick(3);
            chk({13'h0000, fp, cp, tp}, 16'h0000);
        end
        $display("test 4 finished");
        // prescalers only change with the module stopped
        wr(`OFS_SEC_DIV, 16'h0006);
        for (int p = 0; p < 2; p++) begin
            wr(`OFS_MOD_CTRL, 16'h0000);
            wr(`OFS_PRI_DIV, p[15:0]);
            wr(`OFS_CHOP, 16'h8000 | (p[15:0] << 3));
            wr(`OFS_MOD_CTRL, 16'h8000);
            wait_sig(0, 1'b0, 400, n);
            wait_sig(0, 1'b1, 400, n);
            wait_sig(0, 1'b0, 400, n1);
            wait_sig(0, 1'b1, 400, n);
            chk(n1 + n, 16 * (p + 1) * (1 << p));
        end
        wr(`OFS_CHOP, 16'h0000);
        tick(3);
        wait_sig(0, 1'b1, 80, n);
        chk(n, 0);
        $display("test 5 finished");
        wr(`OFS_MOD_CTRL, 16'h0000);
        wr(`OFS_SEC_DIV, 16'h0000);
        wr(`OFS_PRI_DIV, 16'h0000);
        wr(`OFS_STB_CTRL, 16'h0400); // immediate load for the next period write
        wr(`OFS_SEC_PER, 16'h0010); // shortest legal period, low bits zero
        wr(`OFS_SEC_CMP, 16'h0008);
        wr(`OFS_STB_CTRL, 16'h0000);
        wr(`OFS_MOD_CTRL, 16'h8000);
        wait_sig(1, 1'b1, 80, n);
        chk(n, 0);
        for (int ps = 0; ps < 3; ps++) begin
            wr(`OFS_STB_CTRL, 16'h0100 | ps[15:0]);
            wait_sig(2, 1'b1, 500, n);
            wait_sig(2, 1'b1, 500, n);
            cnt = 0;
            for (int c = 0; c < 500; c++) begin
                @(posedge ref_clk);
                #1;
                if (sync_out === 1'b1) cnt++;
                if (sev_trig === 1'b1) break;
            end
            chk(cnt, ps + 1);
        end
        wr(`OFS_STB_CTRL, 16'h0900);
        wait_sig(2, 1'b1, 500, n);
        rd(`OFS_STB_CTRL, v);
        chk(v, 16'h1900);
        wr(`OFS_STB_CTRL, 16'h0800);
        rd(`OFS_STB_CTRL, v);
        chk(v, 16'h0800);
        wr(`OFS_STB_CTRL, 16'h0300);
        wait_sig(1, 1'b0, 200, n);
        tick(1);
        chk({15'h0000, sync_out}, 16'h0001);
        // longest legal period waits for the boundary, then only external sync restarts the timer
        wr(`OFS_SEC_PER, 16'hFFF8);
        wait_sig(1, 1'b0, 200, n);
        wr(`OFS_STB_CTRL, 16'h0180);
        wait_sig(1, 1'b1, 80, n);
        chk(n, 0);
        @(posedge ref_clk);
        sync_lvl <= 1'b1;
        wait_sig(1, 1'b1, 20, n);
        chk(n, 2);
        wr(`OFS_STB_CTRL, 16'h0380);
        sync_lvl <= 1'b0;
        wait_sig(1, 1'b0, 20, n);
        chk(n, 2);
        $display("test 6 finished");
        wrap_up();
    end
endmodule : pwm_secondary_timebase_chop_ctrl_test
`default_nettype wire
